// >>> dthc_pkg.sv
package dthc_pkg;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [3:0]  DTHC_ADDR_CONFIG   = 4'h0;
   localparam logic [3:0]  DTHC_ADDR_STATUS   = 4'h1;
   localparam logic [3:0]  DTHC_ADDR_IRQ_STAT = 4'h2;
   localparam logic [3:0]  DTHC_ADDR_IRQ_MASK = 4'h3;
   localparam logic [31:0] DTHC_CONFIG_RESET  = 32'h0000_0000;
   localparam logic [31:0] DTHC_CONFIG_WMASK  = 32'h0000_5F40;
   // ---------------------------------------------------------------
   // Field positions in debug_config_status
   // ---------------------------------------------------------------
   localparam int DTHC_TRC_BIT  = 14;
   localparam int DTHC_DDC_LO   = 11;
   localparam int DTHC_UHE_BIT  = 10;
   localparam int DTHC_BTB_LO   = 8;
   localparam int DTHC_NPL_BIT  = 6;
   // ---------------------------------------------------------------
   // Interrupt status bits
   // ---------------------------------------------------------------
   localparam int DTHC_IRQ_OPND = 0;
   localparam int DTHC_IRQ_BRT  = 1;
   localparam int DTHC_IRQ_ILL  = 2;
   localparam int DTHC_IRQ_BKPT = 3;
   localparam int DTHC_IRQ_W    = 4;
   // ---------------------------------------------------------------
   // Encodings and timing
   // ---------------------------------------------------------------
   localparam logic [1:0] DTHC_DDC_OFF   = 2'h0;
   localparam logic [1:0] DTHC_SIZE_BYTE = 2'h1;
   localparam logic [1:0] DTHC_SIZE_WORD = 2'h2;
   localparam logic [1:0] DTHC_SIZE_LONG = 2'h3;
   localparam int DTHC_SERIAL_EXTRA_CYC  = 5;
   typedef enum logic [2:0] {
      DTHC_IDLE   = 3'b001,
      DTHC_MARKER = 3'b010,
      DTHC_SHIFT  = 3'b100
   } dthc_state_t;
endpackage : dthc_pkg

// >>> dthc_top.sv
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
// Behaviour
// - Capture select picks which bus operands go onto trace data output.
// - Each captured operand is preceded by a marker giving its size.
// - Byte, word, long show 8, 16, 32 bits, one nibble per trace clock.
// - Select 00 off, 01 writes, 10 reads, 11 reads and writes.
// - Any nonzero select enables partial data trace.
// - User halt permit clear: supervisor only halt; set: user also.
// - Without background debug enable every halt is an illegal opcode.
// - Branch target bytes: 00 none, 01 low two, 1x low three bytes.
// - Serial execution select clear pipelined, set non-pipelined.
// - Non-pipelined runs one instruction at a time, about five extra cycles.
// - PC breakpoint always reported before triggering instruction executes.
// - Pipelined mode may report address/data triggers imprecisely.
// - Non-pipelined mode reports address/data triggers before next instruction.
// - Trace exception enters emulator mode if emulation bit set, else supervisor.
module dthc_top
   import dthc_pkg::*;
#(
   parameter int ADDR_W = 4
) (
   input  wire logic              i_ref_clk,
   input  wire logic              i_reset,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [31:0]       i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic      [31:0]       o_rdata,
   output logic                   o_irq,
   input  wire logic              i_trace_port_clock,
   output logic      [3:0]        o_trace_data_output,
   output logic                   o_trace_valid,
   input  wire logic              i_opnd_valid,
   input  wire logic              i_opnd_write,
   input  wire logic [1:0]        i_opnd_size,
   input  wire logic [31:0]       i_opnd_data,
   input  wire logic              i_branch_valid,
   input  wire logic [31:0]       i_branch_target,
   input  wire logic              i_halt_insn,
   input  wire logic              i_user_mode,
   input  wire logic              i_background_debug_enable,
   input  wire logic              i_trace_exc,
   input  wire logic              i_pc_bkpt,
   input  wire logic              i_addr_data_bkpt,
   input  wire logic              i_insn_boundary,
   output logic                   o_halt_taken,
   output logic                   o_illegal_opcode,
   output logic                   o_serial_exec,
   output logic [2:0]             o_serial_extra_cycles,
   output logic                   o_enter_emulator,
   output logic                   o_enter_supervisor,
   output logic                   o_bkpt_report,
   output logic                   o_bkpt_precise
);
   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   logic [31:0] cfg_reg, cfg_next;
   logic [DTHC_IRQ_W-1:0] ist_reg, ist_next, imask_reg, imask_next;
   logic [31:0] rdata_reg, rdata_next;
   logic irq_reg, irq_next;
   logic [DTHC_IRQ_W-1:0] ev;
   logic [1:0] ddc;
   logic [1:0] branch_target_byte_count;
   logic user_halt_permit, serial_execution_select, trace_exception_emulation;
   logic busy;

   assign ddc = cfg_reg[DTHC_DDC_LO +: 2];
   assign branch_target_byte_count = cfg_reg[DTHC_BTB_LO +: 2];
   assign user_halt_permit = cfg_reg[DTHC_UHE_BIT];
   assign serial_execution_select = cfg_reg[DTHC_NPL_BIT];
   assign trace_exception_emulation = cfg_reg[DTHC_TRC_BIT];

   always_comb begin
      cfg_next   = cfg_reg;
      imask_next = imask_reg;
      rdata_next = 32'h0000_0000;
      // Reserved bits held at zero regardless of what is written
      // reserved stay zero
      if (i_wr && i_addr == DTHC_ADDR_CONFIG) begin
         cfg_next = i_wdata & DTHC_CONFIG_WMASK;
      end
      if (i_wr && i_addr == DTHC_ADDR_IRQ_MASK) begin
         imask_next = i_wdata[DTHC_IRQ_W-1:0];
      end
      // Set wins over write-one-to-clear
      ist_next = (ist_reg & ~((i_wr && i_addr == DTHC_ADDR_IRQ_STAT) ? i_wdata[DTHC_IRQ_W-1:0]
                                                                    : {DTHC_IRQ_W{1'b0}})) | ev;
      if (i_rd) begin
         case (i_addr)
            DTHC_ADDR_CONFIG:   rdata_next = cfg_reg;
            DTHC_ADDR_STATUS:   rdata_next = {29'h0000_0000, o_trace_valid, o_serial_exec, busy};
            DTHC_ADDR_IRQ_STAT: rdata_next = {28'h000_0000, ist_reg};
            DTHC_ADDR_IRQ_MASK: rdata_next = {28'h000_0000, imask_reg};
            default:            rdata_next = 32'h0000_0000;
         endcase
      end
      irq_next = |(ist_next & imask_next);
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         cfg_reg   <= DTHC_CONFIG_RESET;
         ist_reg   <= '0;
         imask_reg <= '0;
         rdata_reg <= 32'h0000_0000;
         irq_reg   <= 1'b0;
      end else begin
         cfg_reg   <= cfg_next;
         ist_reg   <= ist_next;
         imask_reg <= imask_next;
         rdata_reg <= rdata_next;
         irq_reg   <= irq_next;
      end
   end
   assign o_rdata = rdata_reg;
   assign o_irq   = irq_reg;

   // ---------------------------------------------------------------
   // Trace clock synchroniser and edge finder
   // ---------------------------------------------------------------
   logic tck_s1_reg, tck_s2_reg, tck_s3_reg;
   logic tck_rise;
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         tck_s1_reg <= 1'b0;
         tck_s2_reg <= 1'b0;
         tck_s3_reg <= 1'b0;
      end else begin
         tck_s1_reg <= i_trace_port_clock;
         tck_s2_reg <= tck_s1_reg;
         tck_s3_reg <= tck_s2_reg;
      end
   end
   assign tck_rise = tck_s2_reg & ~tck_s3_reg;

   // ---------------------------------------------------------------
   // Trace serialiser
   // ---------------------------------------------------------------
   // Single holding register; captures arriving while busy are dropped
   dthc_state_t st_reg, st_next;
   logic [31:0] sh_reg, sh_next;
   logic [3:0]  mark_reg, mark_next;
   logic [2:0]  nib_reg, nib_next;
   logic [3:0]  dout_reg, dout_next;
   logic        tv_reg, tv_next;
   logic        opnd_take, br_take;

   assign busy = (st_reg != DTHC_IDLE);
   assign opnd_take = i_opnd_valid && (ddc != DTHC_DDC_OFF) &&
                      (i_opnd_write ? ddc[0] : ddc[1]);
   assign br_take = i_branch_valid && (branch_target_byte_count != 2'h0) && !opnd_take;

   always_comb begin
      st_next   = st_reg;
      sh_next   = sh_reg;
      mark_next = mark_reg;
      nib_next  = nib_reg;
      dout_next = dout_reg;
      tv_next   = tv_reg;
      case (st_reg)
         DTHC_IDLE: begin
            if (opnd_take) begin
               sh_next   = i_opnd_data;
               mark_next = {2'h2, i_opnd_size};
               case (i_opnd_size)
                  DTHC_SIZE_BYTE: nib_next = 3'h1;
                  DTHC_SIZE_WORD: nib_next = 3'h3;
                  default:        nib_next = 3'h7;
               endcase
               st_next = DTHC_MARKER;
            end else if (br_take) begin
               sh_next   = i_branch_target;
               mark_next = {2'h1, branch_target_byte_count[1] ? DTHC_SIZE_LONG : DTHC_SIZE_WORD};
               nib_next  = branch_target_byte_count[1] ? 3'h5 : 3'h3;
               st_next   = DTHC_MARKER;
            end
            if (tck_rise) begin
               tv_next   = 1'b0;
               dout_next = 4'h0;
            end
         end
         DTHC_MARKER: begin
            if (tck_rise) begin
               dout_next = mark_reg;
               tv_next   = 1'b1;
               st_next   = DTHC_SHIFT;
            end
         end
         DTHC_SHIFT: begin
            if (tck_rise) begin
               dout_next = sh_reg[3:0];
               sh_next   = {4'h0, sh_reg[31:4]};
               nib_next  = nib_reg - 3'h1;
               if (nib_reg == 3'h0) begin
                  st_next = DTHC_IDLE;
               end
            end
         end
         default: st_next = DTHC_IDLE;
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         st_reg   <= DTHC_IDLE;
         sh_reg   <= 32'h0000_0000;
         mark_reg <= 4'h0;
         nib_reg  <= 3'h0;
         dout_reg <= 4'h0;
         tv_reg   <= 1'b0;
      end else begin
         st_reg   <= st_next;
         sh_reg   <= sh_next;
         mark_reg <= mark_next;
         nib_reg  <= nib_next;
         dout_reg <= dout_next;
         tv_reg   <= tv_next;
      end
   end
   assign o_trace_data_output = dout_reg;
   assign o_trace_valid       = tv_reg;

   // ---------------------------------------------------------------
   // Core control outputs
   // ---------------------------------------------------------------
   logic halt_ok, ill_next, halt_next, emu_next, sup_next, rep_next, prec_next;
   logic halt_reg, ill_reg, emu_reg, sup_reg, rep_reg, prec_reg, ser_reg;
   logic [2:0] xc_reg;
   logic pend_reg, pend_next;

   always_comb begin
      halt_ok   = i_background_debug_enable && (!i_user_mode || user_halt_permit);
      halt_next = i_halt_insn && halt_ok;
      ill_next  = i_halt_insn && !halt_ok;
      emu_next  = i_trace_exc && trace_exception_emulation;
      sup_next  = i_trace_exc && !trace_exception_emulation;
      pend_next = pend_reg;
      rep_next  = 1'b0;
      prec_next = 1'b0;
      if (i_pc_bkpt) begin
         rep_next  = 1'b1;
         prec_next = 1'b1;
      end else if (serial_execution_select) begin
         if (i_addr_data_bkpt || pend_reg) begin
            if (i_insn_boundary) begin
               rep_next  = 1'b1;
               prec_next = 1'b1;
               pend_next = 1'b0;
            end else begin
               pend_next = 1'b1;
            end
         end
      end else if (i_addr_data_bkpt || pend_reg) begin
         rep_next  = 1'b1;
         pend_next = 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         halt_reg <= 1'b0;
         ill_reg  <= 1'b0;
         emu_reg  <= 1'b0;
         sup_reg  <= 1'b0;
         rep_reg  <= 1'b0;
         prec_reg <= 1'b0;
         pend_reg <= 1'b0;
         ser_reg  <= 1'b0;
         xc_reg   <= 3'h0;
      end else begin
         halt_reg <= halt_next;
         ill_reg  <= ill_next;
         emu_reg  <= emu_next;
         sup_reg  <= sup_next;
         rep_reg  <= rep_next;
         prec_reg <= prec_next;
         pend_reg <= pend_next;
         ser_reg  <= cfg_next[DTHC_NPL_BIT];
         xc_reg   <= cfg_next[DTHC_NPL_BIT] ? 3'(DTHC_SERIAL_EXTRA_CYC) : 3'h0;
      end
   end
   assign o_halt_taken       = halt_reg;
   assign o_illegal_opcode   = ill_reg;
   assign o_enter_emulator   = emu_reg;
   assign o_enter_supervisor = sup_reg;
   assign o_bkpt_report      = rep_reg;
   assign o_bkpt_precise     = prec_reg;
   assign o_serial_exec      = ser_reg;
   assign o_serial_extra_cycles = xc_reg;

   // Interrupt events
   assign ev[DTHC_IRQ_OPND] = opnd_take && !busy;
   assign ev[DTHC_IRQ_BRT]  = br_take && !busy;
   assign ev[DTHC_IRQ_ILL]  = ill_next;
   assign ev[DTHC_IRQ_BKPT] = rep_next;
endmodule // dthc_top

// >>> dthc_top_assertions.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Port checker
// ---------------------------------------------------------------
module dthc_top_assertions (
   input wire logic       i_ref_clk,
   input wire logic       i_reset,
   input wire logic       i_halt_insn,
   input wire logic       i_user_mode,
   input wire logic       i_background_debug_enable,
   input wire logic       i_trace_exc,
   input wire logic       i_pc_bkpt,
   input wire logic       i_addr_data_bkpt,
   input wire logic       i_insn_boundary,
   input wire logic       o_halt_taken,
   input wire logic       o_illegal_opcode,
   input wire logic       o_serial_exec,
   input wire logic [2:0] o_serial_extra_cycles,
   input wire logic       o_enter_emulator,
   input wire logic       o_enter_supervisor,
   input wire logic       o_bkpt_report,
   input wire logic       o_bkpt_precise,
   input wire logic       o_trace_valid,
   input wire logic [3:0] o_trace_data_output,
   input wire logic       o_irq
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);
   // Reset itself must be watched, so no disable here
   a_reset_quiet: assert property (disable iff (1'b0)
      i_reset |=> !o_trace_valid && !o_irq && !o_halt_taken) else $error("outputs active after reset");
   a_marker_first: assert property (
      $rose(o_trace_valid) |-> o_trace_data_output[3:2] inside {2'b10, 2'b01}) else $error("no size marker");
   a_halt_super: assert property (
      i_halt_insn && i_background_debug_enable && !i_user_mode |=> o_halt_taken) else $error("halt refused");
   a_halt_illegal: assert property (
      i_halt_insn && !i_background_debug_enable |=> o_illegal_opcode && !o_halt_taken) else $error("halt taken");
   a_extra_cycles: assert property (
      o_serial_extra_cycles == (o_serial_exec ? 3'h5 : 3'h0)) else $error("extra cycle count wrong");
   a_pc_precise: assert property (
      i_pc_bkpt |=> o_bkpt_report && o_bkpt_precise) else $error("pc breakpoint late");
   a_pipe_report: assert property (
      !o_serial_exec && i_addr_data_bkpt && !i_pc_bkpt |=> o_bkpt_report && !o_bkpt_precise)
      else $error("pipelined report wrong");
   a_serial_hold: assert property (
      o_serial_exec && i_addr_data_bkpt && !i_insn_boundary && !i_pc_bkpt |=> !o_bkpt_report)
      else $error("serial report early");
   a_trace_mode: assert property (
      i_trace_exc |=> o_enter_emulator ^ o_enter_supervisor) else $error("trace exception mode wrong");
endmodule // dthc_top_assertions

// >>> dthc_trace_rx.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Debugger side of the trace port
// ---------------------------------------------------------------
module dthc_trace_rx (
   input  wire logic       i_ref_clk,
   input  wire logic [3:0] i_nib,
   input  wire logic       i_valid,
   output logic            o_tclk,
   output logic [3:0]      o_nib,
   output logic            o_got
);
   logic tog_reg = 1'b0;
   logic s1_reg = 1'b0;
   logic s2_reg = 1'b0;
   initial o_tclk = 1'b0;
   always #80 o_tclk = ~o_tclk;
   // one nibble per period, taken mid-period where it is settled
   always @(negedge o_tclk) if (i_valid) begin
      o_nib <= i_nib;
      tog_reg <= ~tog_reg;
   end
   always @(posedge i_ref_clk) begin
      s1_reg <= tog_reg;
      s2_reg <= s1_reg;
   end
   assign o_got = s1_reg ^ s2_reg;
endmodule // dthc_trace_rx

// >>> dthc_top_tb.sv
`timescale 1ns/100ps
module dthc_top_tb;
   import dthc_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
   logic        opv = 1'b0, opw = 1'b0, brv = 1'b0, user = 1'b0, bde = 1'b0;
   logic        halt = 1'b0, texc = 1'b0, pcb = 1'b0, adb = 1'b0, bnd = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [1:0]  opsz = 2'h0;
   logic [31:0] wdata = 32'h0, opd = 32'h0, brt = 32'h0;
   wire logic [31:0] rdata;
   wire logic [3:0]  tnib, pnib;
   wire logic [2:0]  xc;
   wire logic        irq, tclk, tvalid, got, htk, ill, ser, emu, sup, rep, prec;
   logic [31:0] rq[$];
   logic [3:0]  nq[$];
   logic [5:0]  pq[$];
   int          err_total = 0, checked = 0;
   always #2 clk = ~clk;
   dthc_top uut (.i_ref_clk(clk), .i_reset(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
      .o_rdata(rdata), .o_irq(irq), .i_trace_port_clock(tclk), .o_trace_data_output(tnib),
      .o_trace_valid(tvalid), .i_opnd_valid(opv), .i_opnd_write(opw), .i_opnd_size(opsz), .i_opnd_data(opd),
      .i_branch_valid(brv), .i_branch_target(brt), .i_halt_insn(halt), .i_user_mode(user),
      .i_background_debug_enable(bde), .i_trace_exc(texc), .i_pc_bkpt(pcb), .i_addr_data_bkpt(adb),
      .i_insn_boundary(bnd), .o_halt_taken(htk), .o_illegal_opcode(ill), .o_serial_exec(ser),
      .o_serial_extra_cycles(xc), .o_enter_emulator(emu), .o_enter_supervisor(sup), .o_bkpt_report(rep),
      .o_bkpt_precise(prec));
   dthc_trace_rx rx (.i_ref_clk(clk), .i_nib(tnib), .i_valid(tvalid), .o_tclk(tclk), .o_nib(pnib), .o_got(got));
   // ---------------------------------------------------------------
   // Compare and watch
   // ---------------------------------------------------------------
   task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string what);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, g, e);
      end
   endtask
   task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e); cmp(g, e, "read"); endtask
   task automatic cmp_nib(input logic [3:0] g, input logic [3:0] e); cmp({28'h0, g}, {28'h0, e}, "nibble"); endtask
   task automatic cmp_pls(input logic [5:0] g, input logic [5:0] e); cmp({26'h0, g}, {26'h0, e}, "pulse"); endtask
   task automatic cmp_lvl(input logic [31:0] g, input logic [31:0] e); cmp(g, e, "level"); endtask
   always @(posedge clk) begin
      rd_d <= rd;
      if (rd_d) cmp_rd(rdata, rq.size() ? rq.pop_front() : 32'hX);
      if (got) cmp_nib(pnib, nq.size() ? nq.pop_front() : 4'hX);
      if (!rst && {htk, ill, emu, sup, rep, prec} !== 6'h0) cmp_pls({htk, ill, emu, sup, rep, prec},
         pq.size() ? pq.pop_front() : 6'h3F);
   end
   // ---------------------------------------------------------------
   // Drivers
   // ---------------------------------------------------------------
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd_exp(input logic [3:0] a, input logic [31:0] e);
      rq.push_back(e);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
   endtask
   task automatic fire(input logic [4:0] v, input logic [5:0] e);
      if (e != 6'h0) pq.push_back(e);
      {halt, texc, pcb, adb, bnd} <= v;
      @(posedge clk);
      {halt, texc, pcb, adb, bnd} <= 5'h0;
      repeat (3) @(posedge clk);
   endtask
   task automatic settle;
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask
   // Waits for the serialiser to go idle, since captures while busy are lost
   task automatic frame(input logic br, input logic w, input logic [1:0] sz, input logic en);
      logic [31:0] d;
      d = $urandom;
      if (en) begin
         nq.push_back({br ? 2'b01 : 2'b10, sz});
         for (int i = 0; i < (br ? 2 * sz : 1 << sz); i++) nq.push_back(d[4*i+:4]);
      end
      opd <= d;
      brt <= d;
      opw <= w;
      opsz <= sz;
      opv <= !br;
      brv <= br;
      @(posedge clk);
      opv <= 1'b0;
      brv <= 1'b0;
      repeat (60) @(posedge clk);
      for (int k = 0; k < 800 && (nq.size() != 0 || tvalid !== 1'b0); k++) @(posedge clk);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      void'($urandom(10));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd_exp(DTHC_ADDR_CONFIG, DTHC_CONFIG_RESET);
      rd_exp(DTHC_ADDR_STATUS, 32'h0);
      wr_reg(DTHC_ADDR_CONFIG, DTHC_CONFIG_WMASK);
      rd_exp(DTHC_ADDR_CONFIG, DTHC_CONFIG_WMASK);
      rd_exp(4'h9, 32'h0);
      $display("test registers done");
      for (int c = 0; c < 4; c++) for (int s = 1; s < 4; s++) for (int w = 0; w < 2; w++) begin
         wr_reg(DTHC_ADDR_CONFIG, 32'(c) << DTHC_DDC_LO);
         frame(1'b0, w[0], s[1:0], c[w == 1 ? 0 : 1]);
      end
      for (int b = 0; b < 4; b++) begin
         wr_reg(DTHC_ADDR_CONFIG, 32'(b) << DTHC_BTB_LO);
         frame(1'b1, 1'b0, b > 1 ? 2'h3 : 2'h2, b != 0);
      end
      settle;
      cmp_lvl({31'h0, irq}, 32'h0);
      @(posedge clk);
      $display("test trace done");
      wr_reg(DTHC_ADDR_IRQ_MASK, 32'h4);
      for (int h = 0; h < 8; h++) begin
         wr_reg(DTHC_ADDR_CONFIG, 32'(h[0]) << DTHC_UHE_BIT);
         user <= h[1];
         bde <= h[2];
         fire(5'h10, (h[2] && (!h[1] || h[0])) ? 6'h20 : 6'h10);
      end
      settle;
      cmp_lvl({31'h0, irq}, 32'h1);
      @(posedge clk);
      rd_exp(DTHC_ADDR_IRQ_STAT, 32'h7);
      wr_reg(DTHC_ADDR_IRQ_STAT, 32'h4);
      settle;
      cmp_lvl({31'h0, irq}, 32'h0);
      @(posedge clk);
      rd_exp(DTHC_ADDR_IRQ_STAT, 32'h3);
      $display("test halt done");
      wr_reg(DTHC_ADDR_CONFIG, 32'h1 << DTHC_NPL_BIT);
      settle;
      cmp_lvl({28'h0, ser, xc}, 32'hD);
      @(posedge clk);
      fire(5'h04, 6'h03);
      fire(5'h02, 6'h00);
      fire(5'h01, 6'h03);
      wr_reg(DTHC_ADDR_CONFIG, 32'h0);
      fire(5'h02, 6'h02);
      wr_reg(DTHC_ADDR_CONFIG, 32'h1 << DTHC_TRC_BIT);
      fire(5'h08, 6'h08);
      wr_reg(DTHC_ADDR_CONFIG, 32'h0);
      fire(5'h08, 6'h04);
      rd_exp(DTHC_ADDR_IRQ_STAT, 32'hB);
      settle;
      cmp_lvl(32'(rq.size() + nq.size() + pq.size()), 32'h0);
      $display("test core done");
      results;
   end
   initial begin
      #200000;
      err_total++;
      $display("[FAIL] %0t watchdog expired", $time);
      results;
   end
endmodule // dthc_top_tb
bind dthc_top dthc_top_assertions u_chk (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_halt_insn(i_halt_insn),
   .i_user_mode(i_user_mode), .i_background_debug_enable(i_background_debug_enable), .i_trace_exc(i_trace_exc),
   .i_pc_bkpt(i_pc_bkpt), .i_addr_data_bkpt(i_addr_data_bkpt), .i_insn_boundary(i_insn_boundary),
   .o_halt_taken(o_halt_taken), .o_illegal_opcode(o_illegal_opcode), .o_serial_exec(o_serial_exec),
   .o_serial_extra_cycles(o_serial_extra_cycles), .o_enter_emulator(o_enter_emulator),
   .o_enter_supervisor(o_enter_supervisor), .o_bkpt_report(o_bkpt_report), .o_bkpt_precise(o_bkpt_precise),
   .o_trace_valid(o_trace_valid), .o_trace_data_output(o_trace_data_output), .o_irq(o_irq));
